// [common/ciq_pkg.sv]
// constants and types for the command and irq enable register block
//
// Notes on behaviour
// R1 - command register at 01h resets to 20h
// R2 - bit 5 switches analog receiver off
// R3 - writing bit 4 high enters sleep
// R4 - clearing bit 4 wakes; reads one until ready
// R5 - sleep refused while soft restart runs; code checks only when awake, a bit 4 write while waking re-enters sleep
// R6 - known code write launches; read shows running code
// R7 - irq enable register at 02h, reset 80h
// R8 - polarity one drives irq pin inverted
// R9 - polarity zero drives irq pin unchanged
// R10 - reset polarity, open drain: idle pin floats
// R11 - bits 6..4 pass tx, rx, idle requests
// R12 - bits 3..0 pass buffer, fault, timer requests
// R13 - reserved register 00h reads zero
// R14 - output type bit picks push-pull or open-drain
// R15 - unknown command reverts idle, raises idle request
// R16 - irq status is or of enabled flags
package ciq_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int NUM_REQ = 7;
    localparam int CMD_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_RSVD = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_IEN = 6'h02;
    localparam logic [DATA_W-1:0] RSVD_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CMD_RESET = 8'h20;
    localparam logic [DATA_W-1:0] IEN_RESET = 8'h80;
    localparam int CMD_RXOFF_BIT = 5;
    localparam int CMD_SLEEP_BIT = 4;
    localparam int IEN_POL_BIT = 7;
    localparam logic [CMD_W-1:0] CMD_IDLE = 4'h0;
    localparam logic [CMD_W-1:0] CMD_SOFT_RESTART = 4'hf;
    localparam logic [15:0] CMD_VALID_DEFAULT = 16'h81ff;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ciq_req_t;

    // order matches enable bits 6 down to 0
    typedef struct packed {
        logic tx_done_flag;
        logic rx_done_flag;
        logic cmd_idle_flag;
        logic buf_high_flag;
        logic buf_low_flag;
        logic fault_flag;
        logic expiry_flag;
    } ciq_flags_t;

    typedef enum logic [2:0] {
        ST_AWAKE = 3'b001,
        ST_ASLEEP = 3'b010,
        ST_WAKING = 3'b100
    } ciq_sleep_t;
endpackage

// [tb/ciq_host_model.sv]
// host side model issuing single-byte register accesses
module ciq_host_model (
    input logic core_clk,
    output ciq_pkg::ciq_req_t reg_req,
    input logic [ciq_pkg::DATA_W-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ciq_pkg::*;
    initial reg_req = '0;
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge core_clk);
        reg_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge core_clk);
        // released lines show the inverse, never the stale value
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1;
        q = reg_rdata;
    endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the command and irq enable registers
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ciq_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic irq_push_pull = 1'b0;
    logic wake_ready = 1'b0;
    logic cmd_done = 1'b0;
    ciq_flags_t flags = '0;
    ciq_req_t reg_req;
    logic [DATA_W-1:0] reg_rdata, q;
    logic [CMD_W-1:0] cmd_code;
    logic receiver_shutdown, soft_sleep, cmd_launch, idle_req;
    logic irq_status, irq_pin, irq_pin_oe_n;
    int error_cnt = 0;
    int checks_done = 0;
    always #20 core_clk = ~core_clk;
    ciq_host_model i_host (.core_clk(core_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata));
    ciq_regs i_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .flags(flags),
        .irq_push_pull(irq_push_pull), .wake_ready(wake_ready),
        .cmd_done(cmd_done), .receiver_shutdown(receiver_shutdown),
        .soft_sleep(soft_sleep), .cmd_code(cmd_code),
        .cmd_launch(cmd_launch), .idle_req(idle_req),
        .irq_status(irq_status), .irq_pin(irq_pin),
        .irq_pin_oe_n(irq_pin_oe_n));
    // ****************************************
    // scenarios
    // ****************************************
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_host.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a);
        i_host.access(1'b0, a, 8'h00, q);
    endtask
    task automatic pulse_done;
        @(posedge core_clk);
        cmd_done <= 1'b1;
        wake_ready <= 1'b0;
        @(posedge core_clk);
        cmd_done <= 1'b0;
        #1;
        `CHK({cmd_code, idle_req}, 5'h01)
    endtask
    task automatic t_reset;
        `CHK({irq_pin, irq_pin_oe_n, receiver_shutdown}, 3'b111)
        rd(ADDR_RSVD);
        `CHK(q, 8'h00)
        rd(ADDR_CMD);
        `CHK(q, 8'h20)
        rd(ADDR_IEN);
        `CHK(q, 8'h80)
        wr(ADDR_RSVD, 8'hff);
        rd(ADDR_RSVD);
        `CHK(q, 8'h00)
        rd(6'h3f);
        `CHK(q, 8'h00)
    endtask
    task automatic t_sleep;
        wr(ADDR_CMD, 8'h13);
        `CHK({cmd_launch, cmd_code, soft_sleep, receiver_shutdown}, 7'h4e)
        rd(ADDR_CMD);
        `CHK(q, 8'h13)
        wr(ADDR_CMD, 8'h23);
        `CHK({soft_sleep, receiver_shutdown}, 2'b01)
        rd(ADDR_CMD);
        `CHK(q, 8'h33)
        @(posedge core_clk);
        wake_ready <= 1'b1;
        for (int i = 0; i < 8 && q[4]; i++) rd(ADDR_CMD);
        `CHK(q, 8'h23)
        if (q[4]) report_and_stop();
        pulse_done();
    endtask
    task automatic t_commands;
        wr(ADDR_CMD, 8'h1f);
        `CHK({soft_sleep, cmd_code}, 5'h0f)
        rd(ADDR_CMD);
        `CHK(q, 8'h0f)
        pulse_done();
        wr(ADDR_CMD, 8'h0a);
        `CHK({cmd_code, idle_req}, 5'h01)
        wr(ADDR_CMD, 8'h00);
        `CHK({cmd_launch, idle_req}, 2'b10)
        for (int c = 1; c < 9; c++) begin
            wr(ADDR_CMD, 8'(c));
            `CHK(cmd_code, 4'(c))
            rd(ADDR_CMD);
            `CHK(q, 8'(c))
        end
        pulse_done();
    endtask
    task automatic t_sleep_paths;
        wr(ADDR_CMD, 8'h0f);
        wr(ADDR_CMD, 8'h10);
        `CHK({soft_sleep, cmd_code, cmd_launch}, 6'h01)
        wr(ADDR_CMD, 8'h10);
        `CHK(soft_sleep, 1'b1)
        wr(ADDR_CMD, 8'h00);
        `CHK(soft_sleep, 1'b0)
        wr(ADDR_CMD, 8'h10);
        `CHK(soft_sleep, 1'b1)
        wr(ADDR_CMD, 8'h00);
        rd(ADDR_CMD);
        `CHK(q, 8'h10)
        @(posedge core_clk);
        wake_ready <= 1'b1;
        @(posedge core_clk);
        wake_ready <= 1'b0;
        rd(ADDR_CMD);
        `CHK(q, 8'h00)
    endtask
    task automatic t_irq;
        for (int b = 0; b < 7; b++) begin
            @(posedge core_clk);
            flags <= ciq_flags_t'(7'h01 << b);
            irq_push_pull <= 1'b0;
            wr(ADDR_IEN, 8'h01 << b);
            @(posedge core_clk);
            #1;
            `CHK({irq_status, irq_pin}, 2'b11)
            wr(ADDR_IEN, 8'hff ^ (8'h01 << b));
            @(posedge core_clk);
            #1;
            `CHK({irq_status, irq_pin, irq_pin_oe_n}, 3'b011)
            @(posedge core_clk);
            irq_push_pull <= 1'b1;
            @(posedge core_clk);
            #1;
            `CHK(irq_pin_oe_n, 1'b0)
        end
        @(posedge core_clk);
        irq_push_pull <= 1'b0;
        wr(ADDR_IEN, 8'hff);
        @(posedge core_clk);
        #1;
        `CHK({irq_status, irq_pin, irq_pin_oe_n}, 3'b100)
        @(posedge core_clk);
        ce <= 1'b0;
        wr(ADDR_IEN, 8'h00);
        @(posedge core_clk);
        ce <= 1'b1;
        rd(ADDR_IEN);
        `CHK(q, 8'hff)
        wr(ADDR_IEN, 8'h5a);
        rd(ADDR_IEN);
        `CHK(q, 8'h5a)
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_sleep();
        t_commands();
        t_sleep_paths();
        t_irq();
        report_and_stop();
    end
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end
endmodule

// [verilog/ciq_regs.sv]
// command, reserved and irq enable registers with irq pin drive
module ciq_regs #(
    parameter logic [15:0] CMD_VALID_MASK = ciq_pkg::CMD_VALID_DEFAULT
) (
    input logic core_clk,
    input logic rst,
    input logic ce,
    input ciq_pkg::ciq_req_t reg_req,
    output logic [ciq_pkg::DATA_W-1:0] reg_rdata,
    input ciq_pkg::ciq_flags_t flags,
    input logic irq_push_pull,
    input logic wake_ready,
    input logic cmd_done,
    output logic receiver_shutdown,
    output logic soft_sleep,
    output logic [ciq_pkg::CMD_W-1:0] cmd_code,
    output logic cmd_launch,
    output logic idle_req,
    output logic irq_status,
    output logic irq_pin,
    output logic irq_pin_oe_n
);
    import ciq_pkg::*;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic cmd_known(input logic [CMD_W-1:0] code);
        cmd_known = CMD_VALID_MASK[code];
    endfunction

    logic wr_cmd;
    logic wr_ien;
    logic [CMD_W-1:0] wcode;
    logic restart_busy;
    logic irq_any;
    logic pin_next;
    logic rx_off_reg;
    logic [CMD_W-1:0] cmd_reg;
    logic launch_reg;
    logic idle_reg;
    logic [DATA_W-1:0] ien_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic status_reg;
    logic pin_reg;
    logic oe_n_reg;
    ciq_sleep_t sleep_reg;

    assign wr_cmd = ce && reg_req.wr && reg_req.addr == ADDR_CMD;
    assign wr_ien = ce && reg_req.wr && reg_req.addr == ADDR_IEN;
    assign wcode = reg_req.wdata[CMD_W-1:0];
    assign restart_busy = cmd_reg == CMD_SOFT_RESTART
        || (cmd_known(wcode) && wcode == CMD_SOFT_RESTART);

    // ****************************************
    // command register
    // ****************************************
    // R1 R2 reset 20h, receiver off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_off_reg <= CMD_RESET[CMD_RXOFF_BIT];
        end else if (wr_cmd) begin
            rx_off_reg <= reg_req.wdata[CMD_RXOFF_BIT];
        end
    end

    // R6 launch and track command
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_reg <= CMD_RESET[CMD_W-1:0];
            launch_reg <= 1'b0;
            idle_reg <= 1'b0;
        end else if (ce) begin
            launch_reg <= 1'b0;
            idle_reg <= 1'b0;
            if (wr_cmd && cmd_known(wcode)) begin
                cmd_reg <= wcode;
                launch_reg <= 1'b1;
            end else if (wr_cmd) begin
                // R15 unknown code reverts
                cmd_reg <= CMD_IDLE;
                idle_reg <= 1'b1;
            end else if (cmd_done && cmd_reg != CMD_IDLE) begin
                cmd_reg <= CMD_IDLE;
                idle_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // soft sleep and wake
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sleep_reg <= ST_AWAKE;
        end else if (ce) begin
            unique case (sleep_reg)
                ST_AWAKE: begin
                    // R3 R5 enter sleep unless restarting
                    if (wr_cmd && reg_req.wdata[CMD_SLEEP_BIT]
                        && !restart_busy) begin
                        sleep_reg <= ST_ASLEEP;
                    end
                end
                ST_ASLEEP: begin
                    // R4 start wake
                    if (wr_cmd && !reg_req.wdata[CMD_SLEEP_BIT]) begin
                        sleep_reg <= ST_WAKING;
                    end
                end
                ST_WAKING: begin
                    if (wr_cmd && reg_req.wdata[CMD_SLEEP_BIT]) begin
                        sleep_reg <= ST_ASLEEP;
                    end else if (wake_ready) begin
                        sleep_reg <= ST_AWAKE;
                    end
                end
                default: begin
                    sleep_reg <= ST_AWAKE;
                end
            endcase
        end
    end

    // ****************************************
    // irq enable register
    // ****************************************
    // R7 plain read/write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ien_reg <= IEN_RESET;
        end else if (wr_ien) begin
            ien_reg <= reg_req.wdata;
        end
    end

    // ****************************************
    // readback
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= RSVD_RESET;
        end else if (ce && reg_req.rd) begin
            // R13 reserved and unmapped read zero
            rdata_reg <= RSVD_RESET;
            if (reg_req.addr == ADDR_CMD) begin
                rdata_reg[CMD_RXOFF_BIT] <= rx_off_reg;
                // R4 bit reads one while waking
                rdata_reg[CMD_SLEEP_BIT] <= sleep_reg != ST_AWAKE;
                rdata_reg[CMD_W-1:0] <= cmd_reg;
            end else if (reg_req.addr == ADDR_IEN) begin
                rdata_reg <= ien_reg;
            end
        end
    end

    // ****************************************
    // irq pin
    // ****************************************
    // R11 R12 R16 gate and combine requests
    assign irq_any = |(flags & ien_reg[NUM_REQ-1:0]);
    // R8 R9 polarity
    assign pin_next = ien_reg[IEN_POL_BIT] ? !irq_any : irq_any;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= 1'b0;
            pin_reg <= IEN_RESET[IEN_POL_BIT];
            oe_n_reg <= 1'b1;
        end else if (ce) begin
            status_reg <= irq_any;
            pin_reg <= pin_next;
            // R14 R10 push-pull or release when high
            oe_n_reg <= irq_push_pull ? 1'b0 : pin_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign receiver_shutdown = rx_off_reg;
    assign soft_sleep = sleep_reg == ST_ASLEEP;
    assign cmd_code = cmd_reg;
    assign cmd_launch = launch_reg;
    assign idle_req = idle_reg;
    assign irq_status = status_reg;
    assign irq_pin = pin_reg;
    assign irq_pin_oe_n = oe_n_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_rsvd_bits;
        ce && reg_req.rd && reg_req.addr == ADDR_CMD
            |=> reg_rdata[DATA_W-1:CMD_RXOFF_BIT+1] == '0;
    endproperty
    a_rsvd_bits: assert property (p_rsvd_bits) // R1
        else $error("command reserved bits not zero");

    property p_rx_off;
        wr_cmd |=> receiver_shutdown == $past(reg_req.wdata[CMD_RXOFF_BIT]);
    endproperty
    a_rx_off: assert property (p_rx_off) // R2
        else $error("receiver shutdown not written");

    property p_sleep_enter;
        wr_cmd && reg_req.wdata[CMD_SLEEP_BIT] && !restart_busy
            && sleep_reg == ST_AWAKE |=> soft_sleep;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) // R3
        else $error("sleep not entered");

    property p_wake_read;
        ce && reg_req.rd && reg_req.addr == ADDR_CMD && sleep_reg == ST_WAKING
            |=> reg_rdata[CMD_SLEEP_BIT];
    endproperty
    a_wake_read: assert property (p_wake_read) // R4
        else $error("sleep bit not one while waking");

    property p_restart_block;
        wr_cmd && restart_busy && sleep_reg == ST_AWAKE |=> !soft_sleep;
    endproperty
    a_restart_block: assert property (p_restart_block) // R5
        else $error("sleep set during soft restart");

    property p_launch;
        wr_cmd && cmd_known(wcode)
            |=> cmd_code == $past(wcode) && cmd_launch;
    endproperty
    a_launch: assert property (p_launch) // R6
        else $error("command not launched");

    property p_unknown;
        wr_cmd && !cmd_known(wcode) |=> cmd_code == CMD_IDLE && idle_req;
    endproperty
    a_unknown: assert property (p_unknown) // R15
        else $error("unknown command not reverted");

    property p_ien;
        wr_ien |=> ien_reg == $past(reg_req.wdata);
    endproperty
    a_ien: assert property (p_ien) // R7
        else $error("irq enable not written");

    property p_polarity;
        ce |=> irq_pin == ($past(ien_reg[IEN_POL_BIT]) ^ irq_status);
    endproperty
    a_polarity: assert property (p_polarity) // R8
        else $error("irq pin polarity wrong");

    property p_gate;
        ce && (flags & ien_reg[NUM_REQ-1:0]) == '0 |=> !irq_status;
    endproperty
    a_gate: assert property (p_gate) // R11
        else $error("masked request reached irq");

    property p_float;
        ce && !irq_push_pull && ien_reg[IEN_POL_BIT] && !irq_any
            |=> irq_pin_oe_n;
    endproperty
    a_float: assert property (p_float) // R10
        else $error("open drain pin not released");

    property p_push;
        ce && irq_push_pull |=> !irq_pin_oe_n;
    endproperty
    a_push: assert property (p_push) // R14
        else $error("push-pull pin not driven");

    property p_rsvd_read;
        ce && reg_req.rd && reg_req.addr == ADDR_RSVD |=> reg_rdata == '0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) // R13
        else $error("reserved register not zero");

    c_wake: cover property (sleep_reg == ST_WAKING ##1 sleep_reg == ST_AWAKE);
    c_unknown: cover property (wr_cmd && !cmd_known(wcode));
    c_irq: cover property (ce && irq_any ##1 irq_status);
    c_done: cover property (ce && cmd_done && cmd_reg != CMD_IDLE);
endmodule
